/* core/serial_config_regs.v */
/*
  serial slave holding the serial configuration/status register and the
  general control register of a dual-channel led driver.
  assumes chip_select_n, serial_clk, serial_in and reset_pin_n come from
  outside sys_clk; each passes three flip-flops. frames are msb first:
  bit15 rw (1 = write), bits14:10 address, bits9:0 data. parity is odd
  over all bits of a frame. mode 0: sample on rising clock edge, shift out
  on falling edge.
*/
`timescale 1ns/10ps
`default_nettype none
`include "serial_regs_defines.vh"

// Overview of operation
// - frames whose clock count is not a multiple of 16 are rejected, bit 9 set
// - frames failing the parity check are rejected and set bit 8
// - bad write address, write under reset to a register other than the serial one, or nonzero read data set bit 7
// - the three fault flags are latched and cleared by reading the register
// - bit 4 chooses chain readback format, used only in chain mode
// - bits 3..0 enable four pin terminations, reset to 1, 0 disables
// - general bit 8 selects register control; default 0 means pin control
// - bits 7,6 choose register or pin dimming, only under register control
// - bits 5,4 enable each channel converter under register control, reset 0
// - bits 2:0 choose the shared dimming rate from eight codes
// - a combined fault output is the or of the three fault flags
// - the serial register is not reset by the reset pin (bit 6 only records it) and accepts writes under it
module serial_config_regs (
  input  wire        sys_clk,
  input  wire        resetn,
  input  wire        chip_select_n,
  input  wire        serial_clk,
  input  wire        serial_in,
  input  wire        reset_pin_n,
  input  wire        dim_pin_ch1,
  input  wire        dim_pin_ch2,
  input  wire        pin_enable_ch1,
  input  wire        pin_enable_ch2,
  input  wire        duty_dim_ch1,
  input  wire        duty_dim_ch2,
  input  wire [7:0]  device_status,
  output reg         serial_out,
  output reg         serial_out_en,
  output wire        serial_fault,
  output wire        chain_mode,
  output wire        chain_readback_format,
  output wire        reset_pin_pullup_en,
  output wire        select_pin_pullup_en,
  output wire        serial_clock_pulldown_en,
  output wire        serial_in_pulldown_en,
  output wire        register_control_select,
  output wire        ch1_dim_out,
  output wire        ch2_dim_out,
  output wire        ch1_converter_on,
  output wire        ch2_converter_on,
  output wire [2:0]  dimming_rate_code,
  output reg  [11:0] dimming_rate_hz
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  reg  [2:0] cs_sync;
  reg  [2:0] clk_sync;
  reg  [2:0] din_sync;
  reg  [2:0] rst_sync;
  reg        cs_n;
  reg        sck;
  reg        rst_pin_n;

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cs_sync   <= 3'h7;
      clk_sync  <= 3'h0;
      din_sync  <= 3'h0;
      rst_sync  <= 3'h7;
      cs_n      <= 1'b1;
      sck       <= 1'b0;
      rst_pin_n <= 1'b1;
    end else begin
      cs_sync  <= {cs_sync[1:0], chip_select_n};
      clk_sync <= {clk_sync[1:0], serial_clk};
      din_sync <= {din_sync[1:0], serial_in};
      rst_sync <= {rst_sync[1:0], reset_pin_n};
      if (cs_sync[1] == cs_sync[2])
        cs_n <= cs_sync[2];
      if (clk_sync[1] == clk_sync[2])
        sck <= clk_sync[2];
      if (rst_sync[1] == rst_sync[2])
        rst_pin_n <= rst_sync[2];
    end
  end

  wire sck_rise = (clk_sync[1] == clk_sync[2]) && clk_sync[2] && !sck;
  wire sck_fall = (clk_sync[1] == clk_sync[2]) && !clk_sync[2] && sck;
  wire cs_start = (cs_sync[1] == cs_sync[2]) && !cs_sync[2] && cs_n;
  wire cs_end   = (cs_sync[1] == cs_sync[2]) && cs_sync[2] && !cs_n;
  wire din_bit  = din_sync[2];

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg        clk_fault;
  reg        parity_fault;
  reg        access_fault;
  reg        reset_seen_flag;
  reg  [5:0] serial_ctrl;
  reg  [9:0] general_control;

  wire [9:0] serial_config_status = {clk_fault, parity_fault, access_fault,
                                     reset_seen_flag, serial_ctrl};

  function addr_writable;
    input [4:0] a;
    begin
      addr_writable = (a <= `ADDR_LAST_RW);
    end
  endfunction

  function addr_readable;
    input [4:0] a;
    begin
      addr_readable = (a <= `ADDR_LAST_RW) ||
                      (a >= `ADDR_MON_FIRST && a <= `ADDR_MON_LAST);
    end
  endfunction

  // ----------------------------------------------------------------
  // frame receiver
  // ----------------------------------------------------------------
  reg  [15:0] shift_in;
  reg  [15:0] shift_out;
  reg  [9:0]  bit_count;
  reg         parity_acc;
  reg         in_frame;
  reg  [4:0]  last_addr;
  reg         read_cfg_done;

  wire [3:0]  count_mod = bit_count[3:0];
  wire        frame_rw  = shift_in[15];
  wire [4:0]  frame_adr = shift_in[14:10];
  wire [9:0]  frame_dat = shift_in[9:0];
  wire        frame_ok_len = (count_mod == 4'h0) && (bit_count != 10'h000);
  wire        frame_ok_par = parity_acc;
  wire        access_bad =
    frame_rw ? (!addr_writable(frame_adr) ||
                (!rst_pin_n && frame_adr != `ADDR_SERIAL_CFG))
             : (frame_dat != 10'h000 || !addr_readable(frame_adr));
  wire        frame_good = cs_end && in_frame && frame_ok_len && frame_ok_par && !access_bad;
  wire        clk_evt    = cs_end && in_frame && !frame_ok_len;
  wire        par_evt    = cs_end && in_frame && frame_ok_len && !frame_ok_par;
  wire        acc_evt    = cs_end && in_frame && frame_ok_len && frame_ok_par && access_bad;
  wire        word_done  = sck_rise && !cs_n && (count_mod == 4'hF);

  function [9:0] read_word;
    input [4:0] a;
    begin
      case (a)
        `ADDR_NOP:        read_word = `NOP_READ_VALUE;
        `ADDR_SERIAL_CFG: read_word = serial_config_status;
        `ADDR_GENERAL:    read_word = general_control & `GENERAL_WMASK;
        default:          read_word = 10'h000;
      endcase
    end
  endfunction

  // readback word is queued after each complete word; chain format picks header
  wire [15:0] shifted_next    = {shift_in[14:0], din_bit};
  wire [9:0]  read_value_next = read_word(shifted_next[14:10]);
  wire [5:0]  read_hdr = (serial_ctrl[`BIT_CHAIN_MODE] && serial_ctrl[`BIT_CHAIN_FORMAT]) ?
                         device_status[5:0] : shifted_next[15:10];

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      shift_in      <= 16'h0000;
      shift_out     <= 16'h0000;
      bit_count     <= 10'h000;
      parity_acc    <= 1'b0;
      in_frame      <= 1'b0;
      last_addr     <= 5'h00;
      serial_out    <= 1'b0;
      serial_out_en <= 1'b0;
      read_cfg_done <= 1'b0;
    end else begin
      read_cfg_done <= 1'b0;
      if (cs_start) begin
        bit_count     <= 10'h000;
        parity_acc    <= 1'b0;
        in_frame      <= 1'b1;
        serial_out_en <= 1'b1;
      end else if (cs_end) begin
        in_frame      <= 1'b0;
        serial_out_en <= 1'b0;
        if (frame_good && !frame_rw && frame_adr == `ADDR_SERIAL_CFG)
          read_cfg_done <= 1'b1;
        if (frame_good)
          last_addr <= frame_adr;
      end else if (!cs_n) begin
        if (sck_rise) begin
          shift_in   <= {shift_in[14:0], din_bit};
          parity_acc <= parity_acc ^ din_bit;
          bit_count  <= bit_count + 10'h001;
        end
        if (word_done) begin
          shift_out <= {read_hdr, read_value_next};
        end else if (sck_fall) begin
          // the closing falling edge of a word already puts out the next word's msb
          serial_out <= shift_out[15];
          shift_out  <= {shift_out[14:0], 1'b0};
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // register updates
  // ----------------------------------------------------------------
  localparam [9:0] CFG_RESET_WORD = `SERIAL_CFG_RESET;
  localparam [9:0] CFG_WRITE_MASK = `SERIAL_CFG_WMASK;
  wire wr_cfg = frame_good && frame_rw && frame_adr == `ADDR_SERIAL_CFG;
  wire wr_gen = frame_good && frame_rw && frame_adr == `ADDR_GENERAL;

  // serial register is only reset by resetn, never by the reset pin
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      clk_fault       <= 1'b0;
      parity_fault    <= 1'b0;
      access_fault    <= 1'b0;
      reset_seen_flag <= 1'b0;
      serial_ctrl     <= CFG_RESET_WORD[5:0];
    end else begin
      if (clk_evt)
        clk_fault <= 1'b1;
      else if (read_cfg_done)
        clk_fault <= 1'b0;
      if (par_evt)
        parity_fault <= 1'b1;
      else if (read_cfg_done)
        parity_fault <= 1'b0;
      if (acc_evt)
        access_fault <= 1'b1;
      else if (read_cfg_done)
        access_fault <= 1'b0;
      if (!rst_pin_n)
        reset_seen_flag <= 1'b1;
      else if (read_cfg_done)
        reset_seen_flag <= 1'b0;
      if (wr_cfg)
        serial_ctrl <= frame_dat[5:0] & CFG_WRITE_MASK[5:0];
    end
  end

  // general register follows the reset pin as well as resetn
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn)
      general_control <= `GENERAL_RESET;
    else if (!rst_pin_n)
      general_control <= `GENERAL_RESET;
    else if (wr_gen)
      general_control <= frame_dat & `GENERAL_WMASK;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign serial_fault = clk_fault | parity_fault | access_fault;
  assign chain_mode               = serial_ctrl[`BIT_CHAIN_MODE];
  assign chain_readback_format    = serial_ctrl[`BIT_CHAIN_FORMAT];
  assign reset_pin_pullup_en      = serial_ctrl[3];
  assign select_pin_pullup_en     = serial_ctrl[2];
  assign serial_clock_pulldown_en = serial_ctrl[1];
  assign serial_in_pulldown_en    = serial_ctrl[0];
  assign register_control_select  = general_control[`BIT_REG_CTRL];

  wire ch1_reg_dim = register_control_select && general_control[`BIT_CH1_DIM_SRC];
  wire ch2_reg_dim = register_control_select && general_control[`BIT_CH2_DIM_SRC];
  assign ch1_dim_out = ch1_reg_dim ? duty_dim_ch1 : dim_pin_ch1;
  assign ch2_dim_out = ch2_reg_dim ? duty_dim_ch2 : dim_pin_ch2;
  assign ch1_converter_on = register_control_select ?
                            general_control[`BIT_CH1_CONV_EN] : pin_enable_ch1;
  assign ch2_converter_on = register_control_select ?
                            general_control[`BIT_CH2_CONV_EN] : pin_enable_ch2;
  assign dimming_rate_code = general_control[2:0];

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      dimming_rate_hz <= 12'd200;
    end else begin
      case (dimming_rate_code)
        `RATE_CODE_200:  dimming_rate_hz <= 12'd200;
        `RATE_CODE_333:  dimming_rate_hz <= 12'd333;
        `RATE_CODE_400:  dimming_rate_hz <= 12'd400;
        `RATE_CODE_500:  dimming_rate_hz <= 12'd500;
        `RATE_CODE_667:  dimming_rate_hz <= 12'd667;
        `RATE_CODE_1000: dimming_rate_hz <= 12'd1000;
        `RATE_CODE_2000: dimming_rate_hz <= 12'd2000;
        default:         dimming_rate_hz <= 12'd200;
      endcase
    end
  end

endmodule
`default_nettype wire

/* include/serial_regs_defines.vh */
/*
  constants for the serial configuration and general control register pair:
  addresses, field positions, reset values and frame timing.
  assumes a 16-bit serial frame with a 10-bit data field.
*/
`ifndef SERIAL_REGS_DEFINES_VH
`define SERIAL_REGS_DEFINES_VH

`define ADDR_NOP           5'h00
`define ADDR_SERIAL_CFG    5'h01
`define ADDR_GENERAL       5'h02
`define ADDR_LAST_RW       5'h07
`define ADDR_MON_FIRST     5'h0A
`define ADDR_MON_LAST      5'h0F

`define FRAME_BITS         5'd16
`define SERIAL_CFG_RESET   10'h00F
`define GENERAL_RESET      10'h000
`define SERIAL_CFG_WMASK   10'h03F
`define GENERAL_WMASK      10'h1F7
`define NOP_READ_VALUE     10'h009

`define BIT_CLK_FAULT      9
`define BIT_PARITY_FAULT   8
`define BIT_ACCESS_FAULT   7
`define BIT_RESET_SEEN     6
`define BIT_CHAIN_MODE     5
`define BIT_CHAIN_FORMAT   4
`define BIT_REG_CTRL       8
`define BIT_CH1_DIM_SRC    7
`define BIT_CH2_DIM_SRC    6
`define BIT_CH1_CONV_EN    5
`define BIT_CH2_CONV_EN    4

`define RATE_CODE_200      3'h0
`define RATE_CODE_333      3'h1
`define RATE_CODE_400      3'h2
`define RATE_CODE_500      3'h3
`define RATE_CODE_667      3'h4
`define RATE_CODE_1000     3'h5
`define RATE_CODE_2000     3'h6
`define RATE_CODE_200B     3'h7

`endif

/* tb/serial_host_model.sv */
/*
  host-side serial master: sends frames msb first, mode 0, 125 ns clock.
  assumes the bench calls xfer one frame at a time.
*/
`timescale 1ns/10ps
`default_nettype none
module serial_host_model (
  output logic     chip_select_n,
  output logic     serial_clk,
  output logic     serial_in,
  input wire logic serial_out
);
  // ----------------------------------------
  // frame engine
  // ----------------------------------------
  initial begin
    chip_select_n = 1'b1;
    serial_clk    = 1'b0;
    serial_in     = 1'b0;
  end
  // sends the top nbits of w; clock stands low and data is pulled down between frames
  task automatic xfer(input logic [15:0] w, input int nbits, output logic [15:0] rd);
    rd = 16'h0000;
    chip_select_n = 1'b0;
    #62.5;
    for (int i = 15; i > 15 - nbits; i--) begin
      serial_in = w[i];
      #62.5;
      serial_clk = 1'b1;
      rd = {rd[14:0], serial_out};
      #62.5;
      serial_clk = 1'b0;
    end
    #62.5;
    chip_select_n = 1'b1;
    serial_in = 1'b0;
    #200;
  endtask
endmodule
`default_nettype wire

/* tb/serial_regs_props.sv */
/*
  concurrent checks on the ports of the serial register block.
  assumes a 100 MHz sys_clk and three-flop synchronisers on the serial pins.
*/
`timescale 1ns/10ps
`default_nettype none
module serial_regs_props (
  input wire logic        sys_clk,
  input wire logic        resetn,
  input wire logic        chip_select_n,
  input wire logic        reset_pin_n,
  input wire logic        dim_pin_ch1,
  input wire logic        dim_pin_ch2,
  input wire logic        pin_enable_ch1,
  input wire logic        pin_enable_ch2,
  input wire logic        serial_out_en,
  input wire logic        serial_fault,
  input wire logic        chain_mode,
  input wire logic        reset_pin_pullup_en,
  input wire logic        serial_in_pulldown_en,
  input wire logic        register_control_select,
  input wire logic        ch1_dim_out,
  input wire logic        ch2_dim_out,
  input wire logic        ch1_converter_on,
  input wire logic        ch2_converter_on,
  input wire logic [2:0]  dimming_rate_code,
  input wire logic [11:0] dimming_rate_hz
);
  // ----------------------------------------
  // rate table and properties
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  function automatic logic [11:0] hz(input logic [2:0] c);
    case (c)
      3'h1: return 12'h14D;
      3'h2: return 12'h190;
      3'h3: return 12'h1F4;
      3'h4: return 12'h29B;
      3'h5: return 12'h3E8;
      3'h6: return 12'h7D0;
      default: return 12'h0C8;
    endcase
  endfunction
  a_dim1_pin_ctrl: assert property (!register_control_select |-> ch1_dim_out == dim_pin_ch1)
    else $error("ch1 dimming not taken from its pin");
  a_dim2_pin_ctrl: assert property (!register_control_select |-> ch2_dim_out == dim_pin_ch2)
    else $error("ch2 dimming not taken from its pin");
  a_conv1_pin_ctrl: assert property (!register_control_select |-> ch1_converter_on == pin_enable_ch1)
    else $error("ch1 converter not following its pin");
  a_conv2_pin_ctrl: assert property (!register_control_select |-> ch2_converter_on == pin_enable_ch2)
    else $error("ch2 converter not following its pin");
  a_rate_decode: assert property (dimming_rate_hz == hz($past(dimming_rate_code)))
    else $error("dimming rate does not match its code");
  a_fault_rise: assert property ($rose(serial_fault) |-> $past(chip_select_n))
    else $error("fault raised while a frame was running");
  a_fault_clear: assert property ($fell(serial_fault) |-> $past(chip_select_n) && !$past(chip_select_n, 8))
    else $error("fault cleared without a finished frame");
  a_reset_values: assert property (disable iff (1'b0) !resetn && $past(!resetn) |-> reset_pin_pullup_en && serial_in_pulldown_en
    && !chain_mode && !register_control_select && !serial_out_en && dimming_rate_code == 3'h0)
    else $error("reset values wrong");
  a_pin_reset_general: assert property ((!reset_pin_n)[*6] |-> !register_control_select && dimming_rate_code == 3'h0)
    else $error("general register not held by reset pin");
  cover property ($fell(serial_fault));
  cover property ($rose(chain_mode));
  cover property (register_control_select && ch1_converter_on);
endmodule
`default_nettype wire

/* tb/spi_config_and_channel_control_tb_top.sv */
/*
  bench for the serial register pair: frames go through the host model and
  readback and control outputs are compared. assumes core and header compiled.
*/
`timescale 1ns/10ps
`default_nettype none
`include "serial_regs_defines.vh"
module spi_config_and_channel_control_tb_top;
  logic        sys_clk, resetn, reset_pin_n, dim_pin_ch1, dim_pin_ch2, duty_dim_ch1, duty_dim_ch2;
  logic        pin_enable_ch1, pin_enable_ch2;
  logic [7:0]  device_status;
  logic [15:0] rd;
  int          miscompares, comparisons;
  wire logic   chip_select_n, serial_clk, serial_in, serial_out, serial_out_en, serial_fault;
  wire logic   chain_mode, chain_readback_format, reset_pin_pullup_en, select_pin_pullup_en;
  wire logic   serial_clock_pulldown_en, serial_in_pulldown_en, register_control_select;
  wire logic   ch1_dim_out, ch2_dim_out, ch1_converter_on, ch2_converter_on;
  wire logic [2:0]  dimming_rate_code;
  wire logic [11:0] dimming_rate_hz;
  wire logic [15:0] ctl = {8'h00, register_control_select, ch1_dim_out, ch2_dim_out,
                           ch1_converter_on, ch2_converter_on, dimming_rate_code};
  wire logic [15:0] pins = {10'h000, chain_mode, chain_readback_format, reset_pin_pullup_en,
                            select_pin_pullup_en, serial_clock_pulldown_en, serial_in_pulldown_en};
  logic [11:0] rate_hz [8] = '{12'h0C8, 12'h14D, 12'h190, 12'h1F4, 12'h29B, 12'h3E8, 12'h7D0, 12'h0C8};
  logic [15:0] bad [4] = '{16'h8801, 16'h8BF6, 16'hA200, 16'h0403};
  logic [15:0] fbit [4] = '{16'h0200, 16'h0100, 16'h0080, 16'h0080};
  serial_config_regs DUT (.sys_clk, .resetn, .chip_select_n, .serial_clk, .serial_in, .reset_pin_n,
    .dim_pin_ch1, .dim_pin_ch2, .pin_enable_ch1, .pin_enable_ch2, .duty_dim_ch1, .duty_dim_ch2,
    .device_status, .serial_out, .serial_out_en, .serial_fault, .chain_mode, .chain_readback_format,
    .reset_pin_pullup_en, .select_pin_pullup_en, .serial_clock_pulldown_en, .serial_in_pulldown_en,
    .register_control_select, .ch1_dim_out, .ch2_dim_out, .ch1_converter_on, .ch2_converter_on,
    .dimming_rate_code, .dimming_rate_hz);
  serial_host_model host (.chip_select_n, .serial_clk, .serial_in, .serial_out);
  // ----------------------------------------
  // clock, helpers and closing
  // ----------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // odd parity made up through data bit 9, which writes ignore
  function automatic logic [15:0] wr(input logic [4:0] a, input logic [9:0] d);
    logic [15:0] w;
    w = {1'b1, a, d};
    return w ^ {6'h00, ~^w, 9'h000};
  endfunction
  // readback of a word arrives in the frame after the read; a general read carries it
  // out, since a write would be refused while the reset pin is low
  task automatic rd_reg(input logic [4:0] a, output logic [15:0] q);
    host.xfer({1'b0, a, 10'h000}, 16, q);
    host.xfer(16'h0800, 16, q);
  endtask
  task automatic wrap_up;
    $display("mismatches %0d of %0d comparisons", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #400000;
    miscompares++;
    wrap_up();
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    {resetn, reset_pin_n, dim_pin_ch1, dim_pin_ch2, duty_dim_ch1, duty_dim_ch2} = 6'h13;
    {pin_enable_ch1, pin_enable_ch2} = 2'h0;
    device_status = 8'h2A;
    repeat (20) @(negedge sys_clk);
    resetn = 1'b1;
    repeat (10) @(negedge sys_clk);
    rd_reg(`ADDR_SERIAL_CFG, rd);
    check("serial reset", 16'h000F, rd & 16'h03FF);
    rd_reg(`ADDR_GENERAL, rd);
    check("general reset", 16'h0000, rd & 16'h03FF);
    host.xfer(wr(`ADDR_GENERAL, 10'h1FF), 16, rd);
    rd_reg(`ADDR_GENERAL, rd);
    check("general readback", 16'h01F7, rd & 16'h03FF);
    check("register control", 16'h00FF, ctl);
    @(negedge sys_clk) {dim_pin_ch1, dim_pin_ch2, pin_enable_ch1, pin_enable_ch2} = 4'hA;
    host.xfer(wr(`ADDR_GENERAL, 10'h0F5), 16, rd);
    check("pin control", 16'h0055, ctl);
    for (int c = 0; c < 8; c++) begin
      host.xfer(wr(`ADDR_GENERAL, {7'h00, 3'(c)}), 16, rd);
      check("rate hz", {4'h0, rate_hz[c]}, {4'h0, dimming_rate_hz});
    end
    for (int k = 0; k < 4; k++) begin
      host.xfer(bad[k], k == 0 ? 15 : 16, rd);
      check("fault out", 16'h0001, {15'h0000, serial_fault});
      rd_reg(`ADDR_SERIAL_CFG, rd);
      check("fault flag", fbit[k], rd & 16'h0380);
      rd_reg(`ADDR_SERIAL_CFG, rd);
      check("fault cleared", 16'h000F, rd & 16'h03FF);
    end
    rd_reg(`ADDR_GENERAL, rd);
    check("refused unchanged", 16'h0007, rd & 16'h03FF);
    @(negedge sys_clk) reset_pin_n = 1'b0;
    repeat (10) @(negedge sys_clk);
    check("pin held general", 16'h0050, ctl);
    host.xfer(16'h8BF7, 16, rd);
    host.xfer(wr(`ADDR_SERIAL_CFG, 10'h030), 16, rd);
    check("serial under reset", 16'h0030, pins);
    rd_reg(`ADDR_SERIAL_CFG, rd);
    check("chain status read", 16'hA8F0, rd);
    @(negedge sys_clk) reset_pin_n = 1'b1;
    repeat (10) @(negedge sys_clk);
    rd_reg(`ADDR_SERIAL_CFG, rd);
    check("reset seen kept", 16'h0070, rd & 16'h03FF);
    rd_reg(`ADDR_SERIAL_CFG, rd);
    check("reset seen cleared", 16'h0030, rd & 16'h03FF);
    wrap_up();
  end
endmodule
bind serial_config_regs serial_regs_props props (.sys_clk, .resetn, .chip_select_n, .reset_pin_n,
  .dim_pin_ch1, .dim_pin_ch2, .pin_enable_ch1, .pin_enable_ch2, .serial_out_en, .serial_fault,
  .chain_mode, .reset_pin_pullup_en, .serial_in_pulldown_en, .register_control_select,
  .ch1_dim_out, .ch2_dim_out, .ch1_converter_on, .ch2_converter_on, .dimming_rate_code,
  .dimming_rate_hz);
`default_nettype wire
